// [unsigned_multiply_and_negate_exec.sv]
// Top: APB-driven execution of unsigned word multiply and the two negate forms
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module unsigned_multiply_and_negate_exec #(
	parameter int DMEM_WORDS = negmul_pkg::DMEM_WORDS_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [negmul_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import negmul_pkg::*;

	localparam int IW = $clog2(DMEM_WORDS);
	localparam logic [ADDR_W-1:0] DMEM_END = ADR_DMEM_BASE + ADDR_W'(DMEM_WORDS * 4);

	////////////////////////////////////////////////////////////////////////////////
	// State

	logic [15:0] wfile [NUM_W];
	logic [15:0] w_nxt [NUM_W];
	logic [15:0] mem [DMEM_WORDS];

	logic [INSTR_W-1:0] instr_r;
	logic [INSTR_W-1:0] instr_nxt;
	logic exec_r;
	logic exec_nxt;
	logic illegal_r;
	logic illegal_nxt;
	logic [15:0] sr_r;
	logic [15:0] sr_nxt;
	logic [15:0] corctl_r;
	logic [15:0] corctl_nxt;

	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	logic is_mul;
	logic is_lit;
	logic is_negf;
	logic is_negw;
	logic byte_op;
	logic legal;
	logic do_exec;
	logic [3:0] w_f;
	logic [3:0] d_f;
	logic [2:0] p_f;
	logic [2:0] q_f;
	logic [3:0] s_f;
	logic [12:0] f_addr;
	logic dsel;

	// Fields of all three groups; the groups place them differently and they overlap
	always_comb begin
		w_f = instr_r[14:11];
		d_f = instr_r[10:7];
		p_f = instr_r[6:4];
		s_f = instr_r[3:0];
		q_f = instr_r[13:11];
		f_addr = instr_r[12:0];
		dsel = instr_r[13];
	end

	// Opcode recognition; bit 15 must be clear in every group
	always_comb begin
		is_mul = (instr_r[23:20] == OPC_MUL_HI) && (instr_r[19:16] == OPC_MUL_LO) && !instr_r[15];
		is_lit = is_mul && (instr_r[6:5] == LIT_SEL);
		is_negf = (instr_r[23:20] == OPC_NEG_HI) && (instr_r[19:16] == OPC_NEGF_LO) && !instr_r[15];
		is_negw = (instr_r[23:20] == OPC_NEG_HI) && (instr_r[19:16] == OPC_NEGW_LO) && !instr_r[15];
		byte_op = (is_negf || is_negw) && instr_r[14];
		// Odd or W14 destinations would break the register pair convention
		legal = (is_mul && !d_f[0] && (d_f != BAD_WND))
			|| is_negf
			|| (is_negw && (p_f <= MODE_PREINC) && (q_f <= MODE_PREINC));
		do_exec = exec_r && legal;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Operand fetch

	logic [15:0] src_ea;
	logic [15:0] src_ptr_nxt;
	logic src_upd;
	logic [15:0] dst_ea;
	logic [15:0] dst_ptr_nxt;
	logic dst_upd;
	logic [15:0] rd_ea;
	logic [15:0] rd_word;
	logic src_direct;
	logic [15:0] src_opnd;

	operand_addr_unit u_src_addr (
		.mode(p_f),
		.ptr(wfile[s_f]),
		.byte_op(byte_op),
		.ea(src_ea),
		.ptr_nxt(src_ptr_nxt),
		.upd(src_upd)
	);

	operand_addr_unit u_dst_addr (
		.mode(q_f),
		.ptr(wfile[d_f]),
		.byte_op(byte_op),
		.ea(dst_ea),
		.ptr_nxt(dst_ptr_nxt),
		.upd(dst_upd)
	);

	exec_if bus ();

	negate_multiply_alu u_alu (
		.bus(bus.alu_side)
	);

	// File negate always reads memory; others follow the source mode
	always_comb begin
		rd_ea = is_negf ? {3'h0, f_addr} : src_ea;
		rd_word = mem[rd_ea[IW:1]];
		src_direct = !is_negf && (p_f == MODE_DIRECT);
		if (byte_op) begin
			src_opnd = {8'h00, src_direct ? get_byte(wfile[s_f], 1'b0) : get_byte(rd_word, rd_ea[0])};
		end else begin
			src_opnd = src_direct ? wfile[s_f] : rd_word;
		end
	end

	// Control register is never routed here, so mode bits cannot bias the product
	always_comb begin
		bus.op = is_mul ? OP_MUL : ((is_negf || is_negw) ? OP_NEG : OP_NONE);
		bus.byte_op = byte_op;
		bus.opa = wfile[w_f];
		bus.opb = is_lit ? {11'h000, instr_r[4:0]} : src_opnd;
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	logic acc;
	logic in_wfile;
	logic in_dmem;
	logic addr_ok;
	logic commit_wr;
	logic [ADDR_W-1:0] w_off;
	logic [ADDR_W-1:0] m_off;
	logic [3:0] apb_widx;
	logic [IW-1:0] apb_midx;
	logic [31:0] rd_mux;

	always_comb begin
		acc = psel && penable;
		in_wfile = (paddr >= ADR_WFILE_BASE) && (paddr < ADR_WFILE_END);
		in_dmem = (paddr >= ADR_DMEM_BASE) && (paddr < DMEM_END);
		w_off = paddr - ADR_WFILE_BASE;
		m_off = paddr - ADR_DMEM_BASE;
		apb_widx = w_off[5:2];
		apb_midx = m_off[IW+1:2];
		addr_ok = (paddr[1:0] == 2'h0) && (in_wfile || in_dmem || (paddr == ADR_INSTR)
			|| (paddr == ADR_SR) || (paddr == ADR_CORCTL) || (paddr == ADR_XSTAT));
		// Writes land only on the edge where the master sees pready
		commit_wr = acc && pready_r && pwrite && addr_ok;
	end

	// Read data is taken one edge early so pready can come from a flop
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr == ADR_INSTR) begin
			rd_mux = {8'h00, instr_r};
		end else if (paddr == ADR_SR) begin
			rd_mux = {16'h0000, sr_r};
		end else if (paddr == ADR_CORCTL) begin
			rd_mux = {16'h0000, corctl_r};
		end else if (paddr == ADR_XSTAT) begin
			rd_mux[XS_ILLEGAL] = illegal_r;
		end else if (in_wfile) begin
			rd_mux = {16'h0000, wfile[apb_widx]};
		end else if (in_dmem) begin
			rd_mux = {16'h0000, mem[apb_midx]};
		end
		if (!addr_ok) begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_comb begin
		pready_nxt = acc && !pready_r;
		pslverr_nxt = acc && !pready_r && !addr_ok;
		prdata_nxt = (acc && !pready_r && !pwrite) ? rd_mux : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// Control and status registers

	// Writing the instruction word launches one execution cycle
	always_comb begin
		instr_nxt = instr_r;
		exec_nxt = 1'b0;
		corctl_nxt = corctl_r;
		illegal_nxt = exec_r ? !legal : illegal_r;
		if (commit_wr && (paddr == ADR_INSTR)) begin
			instr_nxt = pwdata[INSTR_W-1:0];
			exec_nxt = 1'b1;
		end
		if (commit_wr && (paddr == ADR_CORCTL)) begin
			corctl_nxt = pwdata[15:0];
		end
	end

	// Only negates touch flags; multiply passes them through untouched
	always_comb begin
		sr_nxt = sr_r;
		if (commit_wr && (paddr == ADR_SR)) begin
			sr_nxt = pwdata[15:0];
		end
		if (do_exec && (is_negf || is_negw)) begin
			sr_nxt[SR_C] = bus.flag_c;
			sr_nxt[SR_Z] = bus.flag_z;
			sr_nxt[SR_OVF] = bus.flag_ovf;
			sr_nxt[SR_N] = bus.flag_n;
			sr_nxt[SR_DCARRY] = bus.flag_dcarry;
		end
		// No path from a multiply to the flags
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_r <= INSTR_RST;
			exec_r <= 1'b0;
			illegal_r <= 1'b0;
			sr_r <= SR_RST;
			corctl_r <= CORCTL_RST;
		end else begin
			instr_r <= instr_nxt;
			exec_r <= exec_nxt;
			illegal_r <= illegal_nxt;
			sr_r <= sr_nxt;
			corctl_r <= corctl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Working register write-back

	// Later assignments win: result over pointer update on the same register
	always_comb begin
		w_nxt = wfile;
		if (commit_wr && in_wfile) begin
			w_nxt[apb_widx] = pwdata[15:0];
		end
		if (do_exec) begin
			if ((is_negw || (is_mul && !is_lit)) && src_upd) begin
				w_nxt[s_f] = src_ptr_nxt;
			end
			if (is_negw && dst_upd) begin
				w_nxt[d_f] = dst_ptr_nxt;
			end
			if (is_mul) begin
				w_nxt[d_f] = bus.result;
			end
			if (is_negf && !dsel) begin
				w_nxt[DEF_WORK] = byte_op ? put_byte(wfile[DEF_WORK], bus.result[7:0], 1'b0) : bus.result;
			end
			if (is_negw && (q_f == MODE_DIRECT)) begin
				w_nxt[d_f] = byte_op ? put_byte(wfile[d_f], bus.result[7:0], 1'b0) : bus.result;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_W; i++) begin
				wfile[i] <= 16'h0000;
			end
		end else begin
			wfile <= w_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Data memory write-back

	logic mem_we;
	logic [IW-1:0] mem_idx;
	logic [15:0] mem_wdata;
	logic [1:0] mem_be;

	// Byte stores use one lane; the other lane of the word is kept
	always_comb begin
		mem_we = commit_wr && in_dmem;
		mem_idx = apb_midx;
		mem_wdata = pwdata[15:0];
		mem_be = 2'h3;
		if (do_exec && ((is_negf && dsel) || (is_negw && (q_f != MODE_DIRECT)))) begin
			mem_we = 1'b1;
			mem_idx = is_negf ? f_addr[IW:1] : dst_ea[IW:1];
			mem_wdata = byte_op ? {bus.result[7:0], bus.result[7:0]} : bus.result;
			if (byte_op) begin
				mem_be = (is_negf ? f_addr[0] : dst_ea[0]) ? 2'h2 : 2'h1;
			end
		end
	end

	// Memory contents carry no reset; software loads them before use
	always_ff @(posedge pclk) begin
		if (mem_we && mem_be[0]) begin
			mem[mem_idx][7:0] <= mem_wdata[7:0];
		end
		if (mem_we && mem_be[1]) begin
			mem[mem_idx][15:8] <= mem_wdata[15:8];
		end
	end

endmodule

// [negmul_pkg.sv]
// Shared constants, types and helpers for the multiply and negate datapath
package negmul_pkg;

	localparam int WORD_W = 16;
	localparam int INSTR_W = 24;
	localparam int ADDR_W = 12;
	localparam int NUM_W = 16;
	localparam int DMEM_WORDS_DEF = 64;

	// Opcode nibbles
	localparam logic [3:0] OPC_MUL_HI = 4'hb;
	localparam logic [3:0] OPC_MUL_LO = 4'h8;
	localparam logic [3:0] OPC_NEG_HI = 4'he;
	localparam logic [3:0] OPC_NEGF_LO = 4'he;
	localparam logic [3:0] OPC_NEGW_LO = 4'ha;
	localparam logic [1:0] LIT_SEL = 2'h3;

	// Register selections
	localparam logic [3:0] DEF_WORK = 4'h0;
	localparam logic [3:0] BAD_WND = 4'he;

	// Addressing mode codes
	localparam logic [2:0] MODE_DIRECT = 3'h0;
	localparam logic [2:0] MODE_IND = 3'h1;
	localparam logic [2:0] MODE_POSTDEC = 3'h2;
	localparam logic [2:0] MODE_POSTINC = 3'h3;
	localparam logic [2:0] MODE_PREDEC = 3'h4;
	localparam logic [2:0] MODE_PREINC = 3'h5;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	// APB register map (byte addresses)
	localparam logic [ADDR_W-1:0] ADR_INSTR = 12'h000;
	localparam logic [ADDR_W-1:0] ADR_SR = 12'h004;
	localparam logic [ADDR_W-1:0] ADR_CORCTL = 12'h008;
	localparam logic [ADDR_W-1:0] ADR_XSTAT = 12'h00c;
	localparam logic [ADDR_W-1:0] ADR_WFILE_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] ADR_WFILE_END = 12'h080;
	localparam logic [ADDR_W-1:0] ADR_DMEM_BASE = 12'h100;

	// Status register bits
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_OVF = 2;
	localparam int SR_N = 3;
	localparam int SR_DCARRY = 8;
	localparam int XS_ILLEGAL = 0;

	// Reset values
	localparam logic [15:0] SR_RST = 16'h0000;
	localparam logic [15:0] CORCTL_RST = 16'h0000;
	localparam logic [23:0] INSTR_RST = 24'h00_0000;

	typedef enum logic [1:0] {OP_NONE, OP_MUL, OP_NEG} alu_op_t;

	// Byte lane pick, used for registers and memory, and merge, used for registers only
	function automatic logic [7:0] get_byte(input logic [15:0] w, input logic hi);
		get_byte = hi ? w[15:8] : w[7:0];
	endfunction

	function automatic logic [15:0] put_byte(input logic [15:0] w, input logic [7:0] b, input logic hi);
		put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
	endfunction

endpackage

// [exec_if.sv]
// Operand and result bundle between the core control and the arithmetic unit
`timescale 1ns/10ps
interface exec_if;
	negmul_pkg::alu_op_t op;
	logic byte_op;
	logic [15:0] opa;
	logic [15:0] opb;
	logic [15:0] result;
	logic flag_c;
	logic flag_z;
	logic flag_ovf;
	logic flag_n;
	logic flag_dcarry;
	modport core_side (output op, output byte_op, output opa, output opb,
		input result, input flag_c, input flag_z, input flag_ovf, input flag_n, input flag_dcarry);
	modport alu_side (input op, input byte_op, input opa, input opb,
		output result, output flag_c, output flag_z, output flag_ovf, output flag_n, output flag_dcarry);
endinterface

// [operand_addr_unit.sv]
// Effective address and pointer update for one register operand
`timescale 1ns/10ps
module operand_addr_unit (
	input wire logic [2:0] mode,
	input wire logic [15:0] ptr,
	input wire logic byte_op,
	output logic [15:0] ea,
	output logic [15:0] ptr_nxt,
	output logic upd
);
	import negmul_pkg::*;

	logic [15:0] step;

	// Pointer moves by operand size; pre modes address the moved value
	always_comb begin
		step = byte_op ? STEP_BYTE : STEP_WORD;
		ea = ptr;
		ptr_nxt = ptr;
		upd = 1'b0;
		unique case (mode)
			MODE_DIRECT, MODE_IND: begin
				upd = 1'b0;
			end
			MODE_POSTDEC: begin
				ptr_nxt = ptr - step;
				upd = 1'b1;
			end
			MODE_POSTINC: begin
				ptr_nxt = ptr + step;
				upd = 1'b1;
			end
			MODE_PREDEC: begin
				ptr_nxt = ptr - step;
				ea = ptr_nxt;
				upd = 1'b1;
			end
			MODE_PREINC: begin
				ptr_nxt = ptr + step;
				ea = ptr_nxt;
				upd = 1'b1;
			end
			default: begin
				upd = 1'b0; // Codes 6 and 7 are rejected for a register negate; a multiply takes them as its literal form
			end
		endcase
	end
endmodule

// [negate_multiply_alu.sv]
// Unsigned word multiply and two's complement negate with flags
`timescale 1ns/10ps
module negate_multiply_alu (
	exec_if.alu_side bus
);
	import negmul_pkg::*;

	logic [31:0] prod;
	logic [7:0] x8;
	logic [7:0] r8;
	logic [15:0] r16;

	// Purely combinational; the core registers whatever it keeps
	always_comb begin
		prod = bus.opa * bus.opb;
		x8 = bus.opb[7:0];
		r8 = ~x8 + 8'h01;
		r16 = ~bus.opb + 16'h0001;
		bus.result = 16'h0000;
		bus.flag_c = 1'b0;
		bus.flag_z = 1'b0;
		bus.flag_ovf = 1'b0;
		bus.flag_n = 1'b0;
		bus.flag_dcarry = 1'b0;
		unique case (bus.op)
			OP_MUL: begin
				bus.result = prod[15:0]; // Word only, byte bit ignored
			end
			OP_NEG: begin
				// Carry out of ~x+1 only when x is zero
				if (bus.byte_op) begin
					bus.result = {8'h00, r8};
					bus.flag_n = r8[7];
					bus.flag_z = (r8 == 8'h00);
					bus.flag_ovf = (x8 == 8'h80);
					bus.flag_c = (x8 == 8'h00);
				end else begin
					bus.result = r16;
					bus.flag_n = r16[15];
					bus.flag_z = (r16 == 16'h0000);
					bus.flag_ovf = (bus.opb == 16'h8000);
					bus.flag_c = (bus.opb == 16'h0000);
				end
				bus.flag_dcarry = (x8[3:0] == 4'h0);
			end
			OP_NONE: begin
				bus.result = 16'h0000;
			end
		endcase
	end
endmodule

// [negmul_sva.sv]
// Checker for answer timing, flag retention and illegal-code reporting
`timescale 1ns/10ps
module negmul_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [negmul_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import negmul_pkg::*;
	// Reset stands in for a legal W0*W0, so the cleared illegal bit agrees
	localparam logic [23:0] INS_SAFE = 24'hb8_0000;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic done;
	logic xrd;
	logic keep_r;
	logic [23:0] ins_r;
	logic [15:0] sr_r;
	////////////////////////////////////////////////////////////////
	// Completed access, last instruction and last status seen
	assign done = psel && penable && pready;
	assign xrd = done && !pwrite && paddr == ADR_XSTAT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_r <= INS_SAFE;
			sr_r <= SR_RST;
			keep_r <= 1'b0;
		end else if (done && pwrite && paddr == ADR_INSTR) begin
			ins_r <= pwdata[23:0];
			// Only a multiply may leave the status untouched
			keep_r <= keep_r && pwdata[23:16] == 8'hb8;
		end else if (done && paddr == ADR_SR) begin
			sr_r <= prdata[15:0];
			keep_r <= !pwrite;
		end
	end
	////////////////////////////////////////////////////////////////
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("answer did not come after one wait");
	err_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error flag outside an answer");
	idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data not zero while idle");
	word_only_a: assert property (done && paddr != ADR_INSTR |-> prdata[31:16] == 16'h0000)
		else $error("upper half of a word register not zero");
	mul_flags_a: assert property (done && !pwrite && paddr == ADR_SR && keep_r |-> prdata[15:0] == sr_r)
		else $error("status changed across multiplies");
	mul_legal_a: assert property (xrd && ins_r[23:15] == 9'h170 && !ins_r[7] && ins_r[10:7] != 4'he
		|-> !prdata[XS_ILLEGAL])
		else $error("legal multiply reported illegal");
	bad_dest_a: assert property (xrd && ins_r[23:16] == 8'hb8 && (ins_r[7] || ins_r[10:7] == 4'he)
		|-> prdata[XS_ILLEGAL])
		else $error("bad multiply destination not reported");
	neg_mode_a: assert property (xrd && ins_r[23:16] == 8'hea && (ins_r[6:5] == 2'b11
		|| ins_r[13:12] == 2'b11) |-> prdata[XS_ILLEGAL])
		else $error("bad negate mode not reported");
	bad_code_a: assert property (xrd && !(ins_r[23:16] inside {8'hb8, 8'hee, 8'hea}) |-> prdata[XS_ILLEGAL])
		else $error("unknown opcode not reported");
	cover property (done && pwrite && paddr == ADR_INSTR);
	cover property (done && pslverr);
	cover property (done && !pwrite && paddr == ADR_SR && keep_r);
endmodule
bind unsigned_multiply_and_negate_exec negmul_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

// [unsigned_multiply_and_negate_exec_tb.sv]
// Self-checking bench for the multiply and negate execution block
`timescale 1ns/10ps
module unsigned_multiply_and_negate_exec_tb;
	import negmul_pkg::*;
	typedef struct {string nm; logic [31:0] d; logic e;} note_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	note_t exp_q[$];
	note_t nt;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int k;
	logic [15:0] a, b, x, r, v, w0;
	logic [23:0] bad [4] = '{24'hb8_1f05, 24'hb8_1885, 24'h5a_0000, 24'hea_0263};
	unsigned_multiply_and_negate_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	always #2.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One transfer; the answer is noted before the request goes out
	task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic [31:0] ed,
		input logic ee, input string nm);
		int n;
		n = 0;
		exp_q.push_back('{nm, ed, ee});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) begin
			failures++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
		xfer(1'b1, ad, wd, 32'h0000_0000, 1'b0, "write");
	endtask
	task automatic rd(input logic [11:0] ad, input logic [15:0] ed, input string nm);
		xfer(1'b0, ad, 32'h0000_0000, {16'h0000, ed}, 1'b0, nm);
	endtask
	function automatic logic [11:0] wa(input int n);
		return ADR_WFILE_BASE + 12'(4 * n);
	endfunction
	// Data byte address to its word slot; kept below the wrap point
	function automatic logic [11:0] dm(input logic [15:0] ba);
		return ADR_DMEM_BASE + {4'h0, ba[6:1], 2'b00};
	endfunction
	// Negate flags worked out from the operand and the size
	function automatic logic [15:0] nflags(input logic [15:0] o, input logic bt);
		logic [15:0] s;
		logic [15:0] m;
		logic [15:0] n;
		s = 16'h0000;
		m = bt ? 16'h00ff : 16'hffff;
		n = (16'h0000 - o) & m;
		s[SR_C] = (o & m) == 16'h0000;
		s[SR_Z] = n == 16'h0000;
		s[SR_N] = bt ? n[7] : n[15];
		s[SR_OVF] = (o & m) == (m >> 1) + 16'h0001;
		s[SR_DCARRY] = o[3:0] == 4'h0;
		return s;
	endfunction
	////////////////////////////////////////////////////////////////
	// Takes the oldest note whenever a transfer completes
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			cmp_count++;
			// An answer with no note left can never match
			if (exp_q.size() > 0) begin
				nt = exp_q.pop_front();
			end else begin
				nt.nm = "none";
				nt.d = 32'hxxxx_xxxx;
				nt.e = 1'bx;
			end
			if (prdata !== nt.d || pslverr !== nt.e) begin
				failures++;
				$display("MISMATCH %s expected %h/%b seen %h/%b", nt.nm, nt.d, nt.e, prdata, pslverr);
			end
		end
	end
	// Hang guard well above the planned run
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			failures++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'he63b_eb94));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADR_SR, SR_RST, "sr_rst");
		rd(ADR_CORCTL, CORCTL_RST, "corctl_rst");
		rd(ADR_XSTAT, 16'h0000, "xstat_rst");
		rd(wa(0), 16'h0000, "w0_rst");
		xfer(1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1, "unmapped");
		xfer(1'b1, 12'h041, 32'hffff_ffff, 32'h0000_0000, 1'b1, "misaligned");
		// Both multiply forms under random control and status bits
		for (int i = 0; i < 4; i++) begin
			a = 16'($urandom);
			b = 16'($urandom);
			k = $urandom % 32;
			r = 16'($urandom) & 16'h010f;
			v = 16'(2 * ($urandom % 7));
			wr(ADR_CORCTL, $urandom);
			wr(ADR_SR, {16'h0000, r});
			wr(wa(3), {16'h0000, a});
			wr(wa(5), {16'h0000, b});
			wr(ADR_INSTR, {8'hb8, 1'b0, 4'h3, v[3:0], MODE_DIRECT, 4'h5});
			rd(wa(v), 16'(a * b), "mul_reg");
			wr(ADR_INSTR, {8'hb8, 1'b0, 4'h3, v[3:0], 2'b11, 5'(k)});
			rd(wa(v), 16'(a * k), "mul_lit");
			rd(ADR_SR, r, "mul_sr");
			rd(ADR_XSTAT, 16'h0000, "mul_ok");
		end
		x = 16'($urandom);
		wr(dm(16'h0020), {16'h0000, x});
		wr(wa(5), 32'h0000_0020);
		wr(ADR_INSTR, {8'hb8, 1'b0, 4'h3, 4'h2, MODE_POSTINC, 4'h5});
		rd(wa(2), 16'(a * x), "mul_ind");
		rd(wa(5), 16'h0022, "mul_ptr");
		rd(ADR_SR, r, "mul_sr2");
		// Refused codes raise the illegal bit; the W14 target of one is checked as left alone
		foreach (bad[i]) begin
			wr(ADR_INSTR, {8'h00, bad[i]});
			rd(ADR_XSTAT, 16'h0001, "illegal");
		end
		rd(wa(14), 16'h0000, "w14_kept");
		// File negate over both sizes and destinations, edge operands included
		for (int i = 0; i < 4; i++) begin
			x = i == 2 ? 16'h8000 : i == 3 ? 16'($urandom) & 16'h00ff : 16'($urandom);
			w0 = 16'($urandom);
			v = i[0] ? {8'h00, x[15:8]} : x;
			r = 16'h0000 - v;
			wr(wa(0), {16'h0000, w0});
			wr(dm(16'h0030), {16'h0000, x});
			wr(ADR_SR, 32'h0000_010f);
			wr(ADR_INSTR, {8'hee, 1'b0, i[0], i[1], 13'(16'h0030 | i[0])});
			rd(wa(0), i[1] ? w0 : i[0] ? {w0[15:8], r[7:0]} : r, "negf_w0");
			rd(dm(16'h0030), !i[1] ? x : i[0] ? {r[7:0], x[7:0]} : r, "negf_mem");
			rd(ADR_SR, nflags(v, i[0]), "negf_sr");
		end
		// Register negate through every source mode
		a = 16'($urandom);
		b = 16'($urandom);
		x = 16'($urandom);
		wr(dm(16'h003e), {16'h0000, a});
		wr(dm(16'h0040), {16'h0000, b});
		wr(dm(16'h0042), {16'h0000, x});
		for (int m = 0; m < 6; m++) begin
			v = m == 0 ? 16'h0040 : m == 4 ? a : m == 5 ? x : b;
			k = (m == 2 || m == 4) ? 'h3e : (m == 3 || m == 5) ? 'h42 : 'h40;
			wr(wa(2), 32'h0000_0040);
			wr(ADR_INSTR, {8'hea, 1'b0, 1'b0, MODE_DIRECT, 4'h4, 3'(m), 4'h2});
			rd(wa(4), 16'h0000 - v, "negw");
			rd(wa(2), 16'(k), "negw_ptr");
		end
		// Byte negate into memory through a pre-decremented pointer
		wr(wa(3), {16'h0000, x});
		wr(dm(16'h0022), {16'h0000, b});
		wr(wa(6), 32'h0000_0024);
		wr(ADR_INSTR, {8'hea, 1'b0, 1'b1, MODE_PREDEC, 4'h6, MODE_DIRECT, 4'h3});
		rd(dm(16'h0022), {8'h00 - x[7:0], b[7:0]}, "negw_byte");
		rd(wa(6), 16'h0023, "negw_dptr");
		rd(ADR_SR, nflags({8'h00, x[7:0]}, 1'b1), "negw_sr");
		finish_test();
	end
endmodule
